// ### design/cfg_link_if.sv
// register link between the management host and the configuration store
`timescale 1ns/1ps
interface cfg_link_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;

  modport device (input wr_en, input rd_en, input addr, input wdata,
                  output rdata, output rvalid);
  modport host   (output wr_en, output rd_en, output addr, output wdata,
                  input rdata, input rvalid);
endinterface : cfg_link_if

// ### design/drive_trim_decode.sv
// decoder from one drive trim code to level and output currents
`timescale 1ns/1ps
module drive_trim_decode (
  // trim code
  input  wire logic [3:0] i_code,
  // decoded drive
  output logic      [3:0] o_level,
  output logic            o_off,
  output logic            o_invalid,
  output logic      [7:0] o_cur_100,
  output logic      [7:0] o_cur_85
);
  always_comb begin
    o_off     = 1'b0;
    o_invalid = 1'b0;
    case (i_code)
      feature_cfg_pkg::TRIM_100: o_level = 4'ha;
      feature_cfg_pkg::TRIM_90:  o_level = 4'h9;
      feature_cfg_pkg::TRIM_80:  o_level = 4'h8;
      feature_cfg_pkg::TRIM_70:  o_level = 4'h7;
      feature_cfg_pkg::TRIM_60:  o_level = 4'h6;
      feature_cfg_pkg::TRIM_50:  o_level = 4'h5;
      feature_cfg_pkg::TRIM_40:  o_level = 4'h4;
      feature_cfg_pkg::TRIM_30:  o_level = 4'h3;
      feature_cfg_pkg::TRIM_20:  o_level = 4'h2;
      feature_cfg_pkg::TRIM_10:  o_level = 4'h1;
      feature_cfg_pkg::TRIM_OFF: begin
        o_level = 4'h0;
        o_off   = 1'b1;
      end
      // unlisted codes keep full drive rather than guess a level
      default: begin
        o_level   = feature_cfg_pkg::LEVEL_FULL;
        o_invalid = 1'b1;
      end
    endcase
    o_cur_100 = 8'(o_level * feature_cfg_pkg::STEP_100);
    o_cur_85  = 8'(o_level * feature_cfg_pkg::STEP_85);
  end
endmodule : drive_trim_decode

// ### design/feature_cfg_device.sv
// device end: indirect feature-bit store with drive trims and bypass delay
//
// Overview of operation
// - bypass select picks 2.5 ns or 0.9 ns
// - each of 19 outputs has 4-bit trim
// - trim codes decode to ten levels or off
// - default trim gives 14.0 / 16.0 mA
// - key 0xBB in register 8 unlocks 9, 10
// - register 9 holds target feature-bit index
// - 0x82 in register 10 sets selected bit
// - host writes 0x00 to 10 after each set
// - host changes one differing bit at a time
// - bypass select lives at feature bit 222
// - registers 8, 9, 10 are only path
`timescale 1ns/1ps
module feature_cfg_device #(
  parameter int unsigned NUM_OUTPUTS = feature_cfg_pkg::NUM_OUTPUTS
) (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_nrst,
  // register link
  cfg_link_if.device                    link,
  // drive trim per output
  output logic [NUM_OUTPUTS*4-1:0]      o_output_drive_trim,
  output logic [NUM_OUTPUTS*4-1:0]      o_drive_level,
  output logic [NUM_OUTPUTS-1:0]        o_output_off,
  output logic [NUM_OUTPUTS-1:0]        o_trim_invalid,
  output logic [NUM_OUTPUTS*8-1:0]      o_drive_100_ma_x10,
  output logic [NUM_OUTPUTS*8-1:0]      o_drive_85_ma_x10,
  // bypass delay
  output logic                          o_bypass_fast,
  output logic [11:0]                   o_bypass_delay_ps,
  // access state
  output logic                          o_unlocked
);
  localparam int unsigned FB = feature_cfg_pkg::FEATURE_BITS;

  // trims must end below the bypass bit and fit the index space
  if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 19) begin : g_bad_outputs
    $error("NUM_OUTPUTS must be 1 to 19");
  end

  // trims, bypass bit and the 8-bit index must share one space
  if (feature_cfg_pkg::TRIM_BASE + feature_cfg_pkg::TRIM_W * NUM_OUTPUTS
      > feature_cfg_pkg::BYPASS_BIT) begin : g_bad_trim_span
    $error("trim fields reach the bypass bit");
  end
  if (feature_cfg_pkg::BYPASS_BIT >= FB) begin : g_bad_bypass_bit
    $error("bypass bit lies outside the feature space");
  end
  if (FB != (1 << feature_cfg_pkg::LINK_DATA_W)) begin : g_bad_space
    $error("feature space must match the index width");
  end

  typedef struct packed {
    logic [7:0]                 unlock;
    logic [7:0]                 select;
    logic [7:0]                 write;
    logic [FB-1:0]              feature;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic [NUM_OUTPUTS*4-1:0]   level;
    logic [NUM_OUTPUTS-1:0]     off;
    logic [NUM_OUTPUTS-1:0]     invalid;
    logic [NUM_OUTPUTS*8-1:0]   cur100;
    logic [NUM_OUTPUTS*8-1:0]   cur85;
    logic                       bypass_fast;
    logic [11:0]                bypass_ps;
  } dev_state_t;

  localparam dev_state_t DEV_RST = '{
    unlock:      feature_cfg_pkg::UNLOCK_RST,
    select:      feature_cfg_pkg::SELECT_RST,
    write:       feature_cfg_pkg::WRITE_RST,
    feature:     {FB{feature_cfg_pkg::FEATURE_RST}},
    rdata:       8'h00,
    rvalid:      1'b0,
    level:       {NUM_OUTPUTS{feature_cfg_pkg::LEVEL_FULL}},
    off:         '0,
    invalid:     '0,
    cur100:      {NUM_OUTPUTS{feature_cfg_pkg::FULL_100}},
    cur85:       {NUM_OUTPUTS{feature_cfg_pkg::FULL_85}},
    bypass_fast: 1'b0,
    bypass_ps:   feature_cfg_pkg::BYPASS_SLOW_PS
  };

  dev_state_t                 st_ff;
  dev_state_t                 nxt_st;
  logic                       unlocked;
  logic [NUM_OUTPUTS*4-1:0]   dec_level;
  logic [NUM_OUTPUTS-1:0]     dec_off;
  logic [NUM_OUTPUTS-1:0]     dec_invalid;
  logic [NUM_OUTPUTS*8-1:0]   dec_cur100;
  logic [NUM_OUTPUTS*8-1:0]   dec_cur85;
  logic [NUM_OUTPUTS*4-1:0]   trim_field;
  logic [7:0]                 select_view;
  logic [7:0]                 write_view;

  // a wrong key relocks, so a stray write shuts the path again
  assign unlocked = (st_ff.unlock == feature_cfg_pkg::UNLOCK_KEY);

  // locked registers read as zero, so a probe learns nothing of them
  assign select_view = unlocked ? st_ff.select : 8'h00;
  assign write_view  = unlocked ? st_ff.write : 8'h00;

  // one decoder per output, each on its own slice of the store
  for (genvar n = 0; n < NUM_OUTPUTS; n++) begin : g_trim
    assign trim_field[n*4 +: 4] =
      st_ff.feature[feature_cfg_pkg::TRIM_BASE + 4*n +: 4];

    drive_trim_decode u_decode (
      .i_code    (trim_field[n*4 +: 4]),
      .o_level   (dec_level[n*4 +: 4]),
      .o_off     (dec_off[n]),
      .o_invalid (dec_invalid[n]),
      .o_cur_100 (dec_cur100[n*8 +: 8]),
      .o_cur_85  (dec_cur85[n*8 +: 8])
    );
  end

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;

    // writes: only registers 8, 9 and 10 exist on the link
    if (link.wr_en) begin
      case (link.addr)
        feature_cfg_pkg::REG_UNLOCK: begin
          nxt_st.unlock = link.wdata;
        end
        feature_cfg_pkg::REG_SELECT: begin
          if (unlocked) begin
            nxt_st.select = link.wdata;
          end
        end
        feature_cfg_pkg::REG_WRITE: begin
          if (unlocked) begin
            nxt_st.write = link.wdata;
          end
        end
        default: begin
          // other numbers are not registers of this store
        end
      endcase
    end

    // the set acts while register 10 holds the command; moving the
    // index without first writing 0x00 would set the new bit as well
    if (unlocked && st_ff.write == feature_cfg_pkg::SET_CMD) begin
      nxt_st.feature[st_ff.select] = 1'b1;
    end

    // reads answer one cycle later; locked registers read as zero
    // rdata keeps the last answer, only rvalid marks a fresh one
    if (link.rd_en) begin
      nxt_st.rvalid = 1'b1;
      case (link.addr)
        feature_cfg_pkg::REG_UNLOCK: nxt_st.rdata = st_ff.unlock;
        feature_cfg_pkg::REG_SELECT: nxt_st.rdata = select_view;
        feature_cfg_pkg::REG_WRITE:  nxt_st.rdata = write_view;
        default:                     nxt_st.rdata = 8'h00;
      endcase
    end

    // decoded drive, held in flops
    nxt_st.level   = dec_level;
    nxt_st.off     = dec_off;
    nxt_st.invalid = dec_invalid;
    nxt_st.cur100  = dec_cur100;
    nxt_st.cur85   = dec_cur85;

    // bypass delay select
    // the delay is reported for the analog path, not produced here
    nxt_st.bypass_fast = st_ff.feature[feature_cfg_pkg::BYPASS_BIT];
    if (st_ff.feature[feature_cfg_pkg::BYPASS_BIT]) begin
      nxt_st.bypass_ps = feature_cfg_pkg::BYPASS_FAST_PS;
    end else begin
      nxt_st.bypass_ps = feature_cfg_pkg::BYPASS_SLOW_PS;
    end
  end

  // one register for all state keeps reset and update in step
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= DEV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // link answers
  assign link.rdata  = st_ff.rdata;
  assign link.rvalid = st_ff.rvalid;

  // user side
  // raw trims lead the decoded drive by one cycle
  assign o_output_drive_trim = trim_field;
  assign o_drive_level       = st_ff.level;
  assign o_output_off        = st_ff.off;
  assign o_trim_invalid      = st_ff.invalid;
  assign o_drive_100_ma_x10  = st_ff.cur100;
  assign o_drive_85_ma_x10   = st_ff.cur85;
  assign o_bypass_fast       = st_ff.bypass_fast;
  assign o_bypass_delay_ps   = st_ff.bypass_ps;
  assign o_unlocked          = unlocked;
endmodule : feature_cfg_device

// ### design/feature_cfg_host.sv
// host end: AXI4-Lite command registers driving the configuration link
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module feature_cfg_host #(
  parameter int unsigned AXI_ADDR_W = 4
) (
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_nrst,
  // AXI4-Lite write
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [AXI_ADDR_W-1:0] i_awaddr,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  output logic [1:0]                 o_bresp,
  // AXI4-Lite read
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  input  wire logic [AXI_ADDR_W-1:0] i_araddr,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  // register link
  cfg_link_if.host                   link
);
  if (AXI_ADDR_W < 3) begin : g_bad_addr
    $error("AXI_ADDR_W must be at least 3");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_READ_WAIT, ST_SEQ} host_state_t;

  typedef struct packed {
    host_state_t  state;
    logic [1:0]   step;
    logic         aw_held;
    logic [3:0]   awaddr;
    logic         w_held;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [23:0]  cmd;
    logic [7:0]   rd_byte;
    logic         wr_en;
    logic         rd_en;
    logic [7:0]   addr;
    logic [7:0]   data;
  } host_t;

  host_t st_ff;
  host_t nxt_st;
  logic  busy;

  assign busy = (st_ff.state != ST_IDLE);

  // one step of the set sequence: unlock, select, set, clear
  function automatic logic [15:0] seq_word(input logic [1:0] step, input logic [7:0] idx);
    case (step)
      2'h0:    seq_word = {feature_cfg_pkg::REG_UNLOCK, feature_cfg_pkg::UNLOCK_KEY};
      2'h1:    seq_word = {feature_cfg_pkg::REG_SELECT, idx};
      2'h2:    seq_word = {feature_cfg_pkg::REG_WRITE, feature_cfg_pkg::SET_CMD};
      default: seq_word = {feature_cfg_pkg::REG_WRITE, feature_cfg_pkg::IDLE_CMD};
    endcase
  endfunction : seq_word

  always_comb begin
    logic [23:0] cmd_new;
    logic        go;
    logic [15:0] w;
    cmd_new       = st_ff.cmd;
    go            = 1'b0;
    w             = 16'h0000;
    nxt_st        = st_ff;
    nxt_st.wr_en  = 1'b0;
    nxt_st.rd_en  = 1'b0;

    // address and data may arrive in either order
    if (i_awvalid && !st_ff.aw_held) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr  = 4'(i_awaddr);
    end
    if (i_wvalid && !st_ff.w_held) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata  = i_wdata;
      nxt_st.wstrb  = i_wstrb;
    end
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = feature_cfg_pkg::RESP_OKAY;
      if (st_ff.awaddr == feature_cfg_pkg::HREG_CMD && !busy) begin
        for (int b = 0; b < 3; b++) begin
          if (st_ff.wstrb[b]) begin
            cmd_new[b*8 +: 8] = st_ff.wdata[b*8 +: 8];
          end
        end
        nxt_st.cmd = cmd_new;
        go         = st_ff.wstrb[2];
      end else if (st_ff.awaddr != feature_cfg_pkg::HREG_STATUS) begin
        // commands while busy and unmapped writes are refused
        nxt_st.bresp = feature_cfg_pkg::RESP_SLVERR;
      end
    end else if (st_ff.bvalid && i_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    if (i_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = feature_cfg_pkg::RESP_OKAY;
      nxt_st.rdata  = 32'h0000_0000;
      case (4'(i_araddr))
        feature_cfg_pkg::HREG_CMD:    nxt_st.rdata = {8'h00, st_ff.cmd};
        feature_cfg_pkg::HREG_STATUS: begin
          nxt_st.rdata[feature_cfg_pkg::ST_BUSY_BIT]    = busy;
          nxt_st.rdata[feature_cfg_pkg::ST_RD_LSB +: 8] = st_ff.rd_byte;
        end
        default: nxt_st.rresp = feature_cfg_pkg::RESP_SLVERR;
      endcase
    end else if (st_ff.rvalid && i_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    case (st_ff.state)
      ST_IDLE: begin
        if (go) begin
          nxt_st.addr = cmd_new[feature_cfg_pkg::CMD_ADDR_LSB +: 8];
          nxt_st.data = cmd_new[feature_cfg_pkg::CMD_DATA_LSB +: 8];
          case (cmd_new[feature_cfg_pkg::CMD_OP_LSB +: 2])
            feature_cfg_pkg::OP_WRITE: begin
              nxt_st.wr_en = 1'b1;
              nxt_st.state = ST_WRITE;
            end
            feature_cfg_pkg::OP_READ: begin
              nxt_st.rd_en = 1'b1;
              nxt_st.state = ST_READ_WAIT;
            end
            feature_cfg_pkg::OP_SET_BIT: begin
              w                 = seq_word(2'h0, cmd_new[7:0]);
              {nxt_st.addr, nxt_st.data} = w;
              nxt_st.step       = 2'h0;
              nxt_st.wr_en      = 1'b1;
              nxt_st.state      = ST_SEQ;
            end
            default: begin
            end
          endcase
        end
      end
      ST_WRITE: nxt_st.state = ST_IDLE;
      ST_READ_WAIT: begin
        if (link.rvalid) begin
          nxt_st.rd_byte = link.rdata;
          nxt_st.state   = ST_IDLE;
        end
      end
      ST_SEQ: begin
        // one bit per sequence; clear always follows the set
        if (st_ff.step == 2'h3) begin
          nxt_st.state = ST_IDLE;
        end else begin
          w            = seq_word(2'(st_ff.step + 2'h1), st_ff.cmd[7:0]);
          {nxt_st.addr, nxt_st.data} = w;
          nxt_st.step  = 2'(st_ff.step + 2'h1);
          nxt_st.wr_en = 1'b1;
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= '{state: ST_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_awready  = !st_ff.aw_held;
  assign o_wready   = !st_ff.w_held;
  assign o_bvalid   = st_ff.bvalid;
  assign o_bresp    = st_ff.bresp;
  assign o_arready  = !st_ff.rvalid;
  assign o_rvalid   = st_ff.rvalid;
  assign o_rdata    = st_ff.rdata;
  assign o_rresp    = st_ff.rresp;
  assign link.wr_en = st_ff.wr_en;
  assign link.rd_en = st_ff.rd_en;
  assign link.addr  = st_ff.addr;
  assign link.wdata = st_ff.data;
endmodule : feature_cfg_host

// ### design/feature_cfg_pkg.sv
// shared constants for the feature-bit configuration store and its host
package feature_cfg_pkg;
  // link widths
  localparam int unsigned LINK_ADDR_W = 8;
  localparam int unsigned LINK_DATA_W = 8;
  // link register numbers
  localparam logic [7:0] REG_UNLOCK = 8'h08;
  localparam logic [7:0] REG_SELECT = 8'h09;
  localparam logic [7:0] REG_WRITE  = 8'h0a;
  // command values
  localparam logic [7:0] UNLOCK_KEY = 8'hbb;
  localparam logic [7:0] SET_CMD    = 8'h82;
  localparam logic [7:0] IDLE_CMD   = 8'h00;
  // reset values
  localparam logic [7:0] UNLOCK_RST = 8'h00;
  localparam logic [7:0] SELECT_RST = 8'h00;
  localparam logic [7:0] WRITE_RST  = 8'h00;
  localparam logic       FEATURE_RST = 1'b0;
  // feature-bit space
  localparam int unsigned FEATURE_BITS = 256;
  localparam int unsigned TRIM_BASE    = 140;
  localparam int unsigned TRIM_W       = 4;
  localparam int unsigned NUM_OUTPUTS  = 19;
  localparam int unsigned BYPASS_BIT   = 222;
  // bypass delay in picoseconds
  localparam logic [11:0] BYPASS_SLOW_PS = 12'h9c4;
  localparam logic [11:0] BYPASS_FAST_PS = 12'h384;
  // drive trim codes
  localparam logic [3:0] TRIM_100 = 4'h0;
  localparam logic [3:0] TRIM_90  = 4'h1;
  localparam logic [3:0] TRIM_80  = 4'h3;
  localparam logic [3:0] TRIM_70  = 4'h4;
  localparam logic [3:0] TRIM_60  = 4'h6;
  localparam logic [3:0] TRIM_50  = 4'h7;
  localparam logic [3:0] TRIM_40  = 4'ha;
  localparam logic [3:0] TRIM_30  = 4'hb;
  localparam logic [3:0] TRIM_20  = 4'hc;
  localparam logic [3:0] TRIM_10  = 4'he;
  localparam logic [3:0] TRIM_OFF = 4'hf;
  // drive level in tenths, current in 0.1 mA per tenth
  localparam logic [3:0] LEVEL_FULL = 4'ha;
  localparam logic [7:0] STEP_100   = 8'h0e;
  localparam logic [7:0] STEP_85    = 8'h10;
  localparam logic [7:0] FULL_100   = 8'h8c;
  localparam logic [7:0] FULL_85    = 8'ha0;
  // host register map (byte addresses)
  localparam logic [3:0] HREG_CMD    = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam int unsigned CMD_DATA_LSB = 0;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_OP_LSB   = 16;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_RD_LSB    = 8;
  localparam logic [1:0] OP_WRITE   = 2'h0;
  localparam logic [1:0] OP_READ    = 2'h1;
  localparam logic [1:0] OP_SET_BIT = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : feature_cfg_pkg

// ### test/feature_cfg_properties.sv
// concurrent checks on the configuration link between host and device
`timescale 1ns/1ps
module feature_cfg_properties (
  // clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  // link signals
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  logic [7:0] key_ff;
  logic [7:0] sel_ff;
  logic       open_w;
  assign open_w = (key_ff == feature_cfg_pkg::UNLOCK_KEY);
  // shadow of registers 8 and 9; select only moves while unlocked
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_ff <= 8'h00;
      sel_ff <= 8'h00;
    end else if (wr_en) begin
      if (addr == feature_cfg_pkg::REG_UNLOCK)
        key_ff <= wdata;
      if (addr == feature_cfg_pkg::REG_SELECT && open_w)
        sel_ff <= wdata;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  rd_answer_a: assert property (rd_en |=> rvalid)
    else $error("link read got no answer");
  rvalid_cause_a: assert property (rvalid |-> $past(rd_en))
    else $error("link answer without a read");
  key_read_a: assert property (rd_en && addr == 8'h08 |=> rdata == $past(key_ff))
    else $error("unlock register read wrong");
  locked_read_a: assert property (rd_en && addr == 8'h09 && !open_w |=> rdata == 8'h00)
    else $error("select register visible while locked");
  sel_read_a: assert property (rd_en && addr == 8'h09 && open_w |=> rdata == $past(sel_ff))
    else $error("select register read wrong");
  unmapped_read_a: assert property (rd_en && !(addr inside {[8'h08:8'h0a]}) |=> rdata == 8'h00)
    else $error("unmapped link read not zero");
  set_clear_a: assert property (wr_en && addr == 8'h0a && wdata == 8'h82
    |=> wr_en && addr == 8'h0a && wdata == 8'h00)
    else $error("set not followed by clear");
  reset_rdata_a: assert property ($rose(i_nrst) |-> rdata == 8'h00 && !rvalid)
    else $error("link read state not cleared by reset");
  cover property (wr_en && addr == 8'h0a && wdata == 8'h82);
  cover property (rd_en && addr == 8'h09 && !open_w);
  cover property (rd_en && addr == 8'h07);
endmodule : feature_cfg_properties

// ### test/tb_top.sv
// testbench: host and device joined by the link, driven over AXI4-Lite
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  typedef struct packed {
    logic [4:0] out; logic [3:0] code; logic [3:0] level;
    logic [7:0] c100; logic [7:0] c85; logic inv; logic off;
  } trim_row_t;
  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0]  r;
  logic [75:0] trim, level;
  logic [18:0] off, inv;
  logic [151:0] c100, c85;
  logic        fast, unl;
  logic [11:0] dly;
  int          n_errors = 0;
  int          check_count = 0;
  trim_row_t   rows [12] = '{
    '{5'd0, feature_cfg_pkg::TRIM_100, 4'ha, 8'h8c, 8'ha0, 1'b0, 1'b0},
    '{5'd1, feature_cfg_pkg::TRIM_60, 4'h6, 8'h54, 8'h60, 1'b0, 1'b0},
    '{5'd2, feature_cfg_pkg::TRIM_90, 4'h9, 8'h7e, 8'h90, 1'b0, 1'b0},
    '{5'd3, feature_cfg_pkg::TRIM_80, 4'h8, 8'h70, 8'h80, 1'b0, 1'b0},
    '{5'd4, feature_cfg_pkg::TRIM_70, 4'h7, 8'h62, 8'h70, 1'b0, 1'b0},
    '{5'd5, feature_cfg_pkg::TRIM_50, 4'h5, 8'h46, 8'h50, 1'b0, 1'b0},
    '{5'd6, feature_cfg_pkg::TRIM_40, 4'h4, 8'h38, 8'h40, 1'b0, 1'b0},
    '{5'd7, feature_cfg_pkg::TRIM_30, 4'h3, 8'h2a, 8'h30, 1'b0, 1'b0},
    '{5'd8, feature_cfg_pkg::TRIM_20, 4'h2, 8'h1c, 8'h20, 1'b0, 1'b0},
    '{5'd9, feature_cfg_pkg::TRIM_10, 4'h1, 8'h0e, 8'h10, 1'b0, 1'b0},
    '{5'd18, feature_cfg_pkg::TRIM_OFF, 4'h0, 8'h00, 8'h00, 1'b0, 1'b1},
    '{5'd11, 4'h2, 4'ha, 8'h8c, 8'ha0, 1'b1, 1'b0}};

  cfg_link_if link ();
  feature_cfg_device u_feature_cfg_device (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .link(link), .o_output_drive_trim(trim), .o_drive_level(level), .o_output_off(off),
    .o_trim_invalid(inv), .o_drive_100_ma_x10(c100), .o_drive_85_ma_x10(c85),
    .o_bypass_fast(fast), .o_bypass_delay_ps(dly), .o_unlocked(unl));
  feature_cfg_host u_feature_cfg_host (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid),
    .i_bready(1'b1), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(1'b1), .o_rdata(rdata),
    .o_rresp(rresp), .link(link));
  feature_cfg_properties u_feature_cfg_properties (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid));

  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // design flops update after this wakes, so values read at the edge are pre-edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] re);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    do begin
      @(posedge i_sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    re = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] re);
    arvalid <= 1'b1;
    araddr  <= a;
    do begin
      @(posedge i_sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v  = rdata;
    re = rresp;
  endtask : axi_rd

  // one link operation, then poll status until the sequence is over
  task automatic link_op(input logic [1:0] op, input logic [7:0] a, input logic [7:0] v);
    axi_wr(feature_cfg_pkg::HREG_CMD, {14'h0000, op, a, v}, r);
    do axi_rd(feature_cfg_pkg::HREG_STATUS, d, r); while (d[0] !== 1'b0);
    repeat (4) @(posedge i_sys_clk);
  endtask : link_op

  task automatic read_reg(input logic [7:0] a);
    link_op(feature_cfg_pkg::OP_READ, a, 8'h00);
    axi_rd(feature_cfg_pkg::HREG_STATUS, d, r);
  endtask : read_reg

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge i_sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    logic [1:0] r2;
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(posedge i_sys_clk);
    `CHK("trim", 76'h0, trim)
    `CHK("cur100", feature_cfg_pkg::FULL_100, c100[7:0])
    `CHK("cur85", feature_cfg_pkg::FULL_85, c85[151:144])
    `CHK("dly", feature_cfg_pkg::BYPASS_SLOW_PS, dly)
    `CHK("unl", 1'b0, unl)
    axi_rd(4'h8, d, r);
    `CHK("unmapped", feature_cfg_pkg::RESP_SLVERR, r)
    link_op(feature_cfg_pkg::OP_WRITE, feature_cfg_pkg::REG_SELECT, 8'h55);
    read_reg(feature_cfg_pkg::REG_SELECT);
    `CHK("locked sel", 8'h00, d[15:8])
    link_op(feature_cfg_pkg::OP_WRITE, feature_cfg_pkg::REG_UNLOCK, 8'hbb);
    `CHK("unl", 1'b1, unl)
    read_reg(feature_cfg_pkg::REG_SELECT);
    `CHK("sel kept", 8'h00, d[15:8])
    link_op(feature_cfg_pkg::OP_WRITE, feature_cfg_pkg::REG_UNLOCK, 8'h11);
    `CHK("relock", 1'b0, unl)
    read_reg(8'h07);
    `CHK("link unmapped", 8'h00, d[15:8])
    // only set bits change; code 0110 on output 1 takes two set cycles
    foreach (rows[i])
      for (int b = 0; b < 4; b++)
        if (rows[i].code[b])
          link_op(feature_cfg_pkg::OP_SET_BIT, 8'h00, 8'(140 + 4 * rows[i].out + b));
    foreach (rows[i]) begin
      `CHK("field", rows[i].code, trim[rows[i].out*4 +: 4])
      `CHK("level", rows[i].level, level[rows[i].out*4 +: 4])
      `CHK("c100", rows[i].c100, c100[rows[i].out*8 +: 8])
      `CHK("c85", rows[i].c85, c85[rows[i].out*8 +: 8])
      `CHK("inv", rows[i].inv, inv[rows[i].out])
      `CHK("off", rows[i].off, off[rows[i].out])
    end
    `CHK("untouched", 4'h0, trim[40 +: 4])
    read_reg(feature_cfg_pkg::REG_SELECT);
    `CHK("index", 8'hb9, d[15:8])
    read_reg(feature_cfg_pkg::REG_WRITE);
    `CHK("cleared", 8'h00, d[15:8])
    link_op(feature_cfg_pkg::OP_SET_BIT, 8'h00, 8'hde);
    `CHK("fast", 1'b1, fast)
    `CHK("dly", feature_cfg_pkg::BYPASS_FAST_PS, dly)
    `CHK("out17", 4'h0, trim[68 +: 4])
    // a second command while the first sequence runs must be refused
    axi_wr(feature_cfg_pkg::HREG_CMD, 32'h0002_00de, r);
    axi_wr(feature_cfg_pkg::HREG_CMD, 32'h0002_008c, r2);
    `CHK("busy", feature_cfg_pkg::RESP_SLVERR, r2)
    link_op(2'h3, 8'h00, 8'h00);
    `CHK("bit140", 1'b0, trim[0])
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(posedge i_sys_clk);
    `CHK("trim", 76'h0, trim)
    `CHK("fast", 1'b0, fast)
    report_and_stop();
  end
endmodule : tb_top
